// ==== dv/jtag_ctl.sv ====
`timescale 1ns/1ns
module jtag_ctl (
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    // Test clock stands still low between frames
    initial
    begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h0;
    end

    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #80 tdo = tdo_i;
        tck_o = 1'h1;
        #80 tck_o = 1'h0;
    endtask : step

    task automatic reset_tap();
        logic d;
        repeat (5) step(1'h1, 1'h0, d);
        step(1'h0, 1'h0, d);
    endtask : reset_tap

    // One full IR or DR frame from idle back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic d;
        dout = '0;
        step(1'h1, 1'h0, d);
        if (ir)
            step(1'h1, 1'h0, d);
        step(1'h0, 1'h0, d);
        step(1'h0, 1'h0, d);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        step(1'h1, 1'h0, d);
        step(1'h0, 1'h0, d);
        // Released data line must not keep its last value
        tdi_o = ~tdi_o;
        // Update reaches the pins through the synchroniser before any check
        #80;
    endtask : scan
endmodule : jtag_ctl

// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb;
    localparam int TS = 20;
    localparam int TL = 40;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       twice;
        logic [7:0] exp;
    } csr_row_s;
    logic        clk, srst, tck, tms, tdi, tdo, tdo_oe, fuse_en, fuse_sel;
    logic        part_rst, wr, rd, oe_seen, ext_rst_n;
    logic [7:0]  pin_i, pin_o, pin_oe, sys_out, sys_oe, addr, wdata, rdata;
    logic [31:0] dout;
    int          n;
    int          err_count = 0;
    int          samples_checked = 0;
    csr_row_s    rows [5] = '{'{8'h00, 8'h40, 1'h0, 8'h40}, '{8'h00, 8'hC0, 1'h0, 8'h40},
                              '{8'h01, 8'hFF, 1'h0, 8'h00}, '{8'h00, 8'h80, 1'h1, 8'h80},
                              '{8'h00, 8'h00, 1'h1, 8'h00}};

    bscan_tap #(.NPINS(8), .TOUT_SHORT(TS), .TOUT_LONG(TL)) DUT (
        .CORE_CLK_I(clk), .SRST_I(srst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TDO_O(tdo), .TDO_OE_O(tdo_oe), .TAP_ENABLE_FUSE_I(fuse_en),
        .TOUT_SEL_FUSE_I(fuse_sel), .EXT_RESET_N_I(ext_rst_n), .PIN_I(pin_i), .PIN_O(pin_o),
        .PIN_OE_O(pin_oe), .SYS_OUT_I(sys_out), .SYS_OE_I(sys_oe), .PART_RESET_O(part_rst),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));

    jtag_ctl jtag (.tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
        if (tdo_oe === 1'h1)
            oe_seen = 1'h1;

    task automatic results();
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr_csr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_csr

    task automatic rd_csr(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 check(rdata, e);
    endtask : rd_csr

    // Bounded wait for the part reset to drop
    task automatic count_rst();
        n = 0;
        while (part_rst === 1'h1 && n < 500)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 500)
        begin
            err_count++;
            $display("[ERR] %0t part reset never released", $time);
            results();
        end
    endtask : count_rst

    initial
    begin
        srst = 1'h1;
        ext_rst_n = 1'h1;
        fuse_en = 1'h1;
        fuse_sel = 1'h0;
        wr = 1'h0;
        rd = 1'h0;
        addr = 8'h00;
        wdata = 8'h00;
        pin_i = 8'hC3;
        sys_out = 8'h5A;
        sys_oe = 8'hFF;
        oe_seen = 1'h0;
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk);
            fuse_sel <= s[0];
            srst <= 1'h1;
            repeat (16) @(posedge clk);
            check(pin_oe, 8'h00);
            srst <= 1'h0;
            // Core reset itself has no time-out; the external pin does
            repeat (4) @(posedge clk);
            ext_rst_n <= 1'h0;
            repeat (4) @(posedge clk);
            check(part_rst, 1'h1);
            check(pin_oe, 8'h00);
            ext_rst_n <= 1'h1;
            count_rst();
            check(n >= (s ? TL : TS) && n <= (s ? TL : TS) + 4, 1'h1);
            rd_csr(bscan_pkg::CSR_ADDR, 8'h00);
        end
        foreach (rows[i])
        begin
            wr_csr(rows[i].addr, rows[i].wdata);
            if (rows[i].twice)
                wr_csr(rows[i].addr, rows[i].wdata);
            rd_csr(rows[i].addr, rows[i].exp);
        end
        // Second write lands six cycles after the first: too late
        wr_csr(bscan_pkg::CSR_ADDR, 8'h80);
        repeat (4) @(posedge clk);
        wr_csr(bscan_pkg::CSR_ADDR, 8'h80);
        rd_csr(bscan_pkg::CSR_ADDR, 8'h00);
        jtag.reset_tap();
        oe_seen = 1'h0;
        jtag.scan(1'h0, 32, 32'h0, dout);
        check(dout, {bscan_pkg::ID_REV, bscan_pkg::ID_PART, bscan_pkg::ID_MAKER, 1'h1});
        check(oe_seen, 1'h1);
        jtag.scan(1'h1, 4, 32'hF, dout);
        check(dout[3:0], bscan_pkg::IR_CAPTURE);
        jtag.scan(1'h0, 4, 32'hB, dout);
        check(dout[3:0], 4'h6);
        jtag.scan(1'h1, 4, bscan_pkg::OP_SAMPLE, dout);
        jtag.scan(1'h0, 16, 32'h9600, dout);
        check(dout[15:0], 16'h5AC3);
        check(pin_o, 8'h5A);
        jtag.scan(1'h1, 4, bscan_pkg::OP_EXTEST, dout);
        check(pin_o, 8'h96);
        @(posedge clk);
        pin_i <= 8'h3C;
        fuse_sel <= 1'h1;
        jtag.scan(1'h0, 16, 32'h0F00, dout);
        check(dout[15:0], 16'h963C);
        check(pin_o, 8'h0F);
        jtag.scan(1'h1, 4, bscan_pkg::OP_PART_RESET, dout);
        jtag.scan(1'h0, 1, 32'h1, dout);
        check(part_rst, 1'h1);
        check(pin_oe, 8'h00);
        jtag.scan(1'h0, 1, 32'h1, dout);
        check(dout[0], 1'h1);
        rd_csr(bscan_pkg::CSR_ADDR, 8'h10);
        jtag.scan(1'h0, 1, 32'h0, dout);
        check(part_rst, 1'h1);
        count_rst();
        wr_csr(bscan_pkg::CSR_ADDR, 8'h00);
        rd_csr(bscan_pkg::CSR_ADDR, 8'h00);
        // Unconnected port: software turns it off
        wr_csr(bscan_pkg::CSR_ADDR, 8'h80);
        wr_csr(bscan_pkg::CSR_ADDR, 8'h80);
        oe_seen = 1'h0;
        jtag.reset_tap();
        jtag.scan(1'h0, 32, 32'h0, dout);
        check(oe_seen, 1'h0);
        wr_csr(bscan_pkg::CSR_ADDR, 8'h00);
        wr_csr(bscan_pkg::CSR_ADDR, 8'h00);
        fuse_en <= 1'h0;
        oe_seen = 1'h0;
        jtag.scan(1'h0, 32, 32'h0, dout);
        check(oe_seen, 1'h0);
        results();
    end
endmodule : tb

// ==== rtl/bscan_pkg.sv ====
package bscan_pkg;
    localparam int IR_W = 4;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EX1_DR, PAUSE_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EX1_IR, PAUSE_IR, EX2_IR, UPD_IR
    } tap_state_e;
    localparam logic [3:0] OP_EXTEST     = 4'h0;
    localparam logic [3:0] OP_IDCODE     = 4'h1;
    localparam logic [3:0] OP_SAMPLE     = 4'h2;
    localparam logic [3:0] OP_PART_RESET = 4'hC;
    localparam logic [3:0] OP_BYPASS     = 4'hF;
    localparam logic [3:0] IR_CAPTURE    = 4'h1;
    localparam int         ADDR_W        = 8;
    localparam logic [7:0] CSR_ADDR      = 8'h00;
    localparam logic [7:0] CSR_RESET     = 8'h00;
    localparam int         DIS_BIT       = 7;
    localparam int         ISC_BIT       = 6;
    localparam int         TRF_BIT       = 4;
    localparam logic [2:0] TIMED_WIN     = 3'h4;
    // Identity fields, values arbitrary
    localparam logic [3:0]  ID_REV       = 4'h3;
    localparam logic [15:0] ID_PART      = 16'hA5C3;
    localparam logic [10:0] ID_MAKER     = 11'h155;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int TOUT_SHORT_NS  = 4100000;
    localparam int TOUT_LONG_NS   = 65000000;
    localparam int TOUT_SHORT_CYC = (TOUT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOUT_LONG_CYC  = (TOUT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] SYNC_RESET = 6'h01;
endpackage : bscan_pkg

// ==== rtl/bscan_tap.sv ====
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - Identification instruction is loaded whenever the tap sits in reset.
// - Loading external-test drives latched output values onto pins at once.
// - External test samples pin levels into the ring and drives outputs from it.
// - Port works only with enable fuse programmed and disable bit clear.
// - Test clock is independent of core clock; its edges are detected, not used.
// - Bypass is one stage, zero after capture when selected.
// - Identification word: revision 31:28, part 27:12, maker 11:1, bit0 one.
// - A one in the test reset register holds the whole part in reset.
// - Test reset register acts directly, with no update latch.
// - After test reset release, reset holds for the fuse-selected time-out.
// - Any reset puts every pin into high impedance immediately.
// - Code 0x2 selects the ring; update loads latches without driving pins.
// - Sample/preload captures pin levels and shifts the ring on test clock.
// - Code 0xC selects the one-bit test reset register, tap not reset.
// - Code 0xF selects bypass; capture loads zero, shift passes one cell.
// - Control bit 7 disables the port when set.
// - Disable bit changes only on two equal writes within four cycles.
// - Flag bit 4 set by test reset; cleared by power-on reset or writing zero.
module bscan_tap #(
    parameter int NPINS      = 8,
    parameter int TOUT_SHORT = bscan_pkg::TOUT_SHORT_CYC,
    parameter int TOUT_LONG  = bscan_pkg::TOUT_LONG_CYC
) (
    input  wire logic                          CORE_CLK_I,
    input  wire logic                          SRST_I,
    input  wire logic                          TCK_I,
    input  wire logic                          TMS_I,
    input  wire logic                          TDI_I,
    output logic                               TDO_O,
    output logic                               TDO_OE_O,
    input  wire logic                          TAP_ENABLE_FUSE_I,
    input  wire logic                          TOUT_SEL_FUSE_I,
    input  wire logic                          EXT_RESET_N_I,
    input  wire logic [NPINS-1:0]              PIN_I,
    output logic      [NPINS-1:0]              PIN_O,
    output logic      [NPINS-1:0]              PIN_OE_O,
    input  wire logic [NPINS-1:0]              SYS_OUT_I,
    input  wire logic [NPINS-1:0]              SYS_OE_I,
    output logic                               PART_RESET_O,
    input  wire logic [bscan_pkg::ADDR_W-1:0]  ADDR_I,
    input  wire logic [7:0]                    WDATA_I,
    input  wire logic                          WR_I,
    input  wire logic                          RD_I,
    output logic      [7:0]                    RDATA_O
);
    localparam int RL = 2 * NPINS;

    function automatic bscan_pkg::tap_state_e tap_next(input bscan_pkg::tap_state_e s,
                                                       input logic m);
        bscan_pkg::tap_state_e n;
        n = s;
        case (s)
            bscan_pkg::TLR:      n = m ? bscan_pkg::TLR      : bscan_pkg::RTI;
            bscan_pkg::RTI:      n = m ? bscan_pkg::SEL_DR   : bscan_pkg::RTI;
            bscan_pkg::SEL_DR:   n = m ? bscan_pkg::SEL_IR   : bscan_pkg::CAP_DR;
            bscan_pkg::CAP_DR:   n = m ? bscan_pkg::EX1_DR   : bscan_pkg::SHIFT_DR;
            bscan_pkg::SHIFT_DR: n = m ? bscan_pkg::EX1_DR   : bscan_pkg::SHIFT_DR;
            bscan_pkg::EX1_DR:   n = m ? bscan_pkg::UPD_DR   : bscan_pkg::PAUSE_DR;
            bscan_pkg::PAUSE_DR: n = m ? bscan_pkg::EX2_DR   : bscan_pkg::PAUSE_DR;
            bscan_pkg::EX2_DR:   n = m ? bscan_pkg::UPD_DR   : bscan_pkg::SHIFT_DR;
            bscan_pkg::UPD_DR:   n = m ? bscan_pkg::SEL_DR   : bscan_pkg::RTI;
            bscan_pkg::SEL_IR:   n = m ? bscan_pkg::TLR      : bscan_pkg::CAP_IR;
            bscan_pkg::CAP_IR:   n = m ? bscan_pkg::EX1_IR   : bscan_pkg::SHIFT_IR;
            bscan_pkg::SHIFT_IR: n = m ? bscan_pkg::EX1_IR   : bscan_pkg::SHIFT_IR;
            bscan_pkg::EX1_IR:   n = m ? bscan_pkg::UPD_IR   : bscan_pkg::PAUSE_IR;
            bscan_pkg::PAUSE_IR: n = m ? bscan_pkg::EX2_IR   : bscan_pkg::PAUSE_IR;
            bscan_pkg::EX2_IR:   n = m ? bscan_pkg::UPD_IR   : bscan_pkg::SHIFT_IR;
            bscan_pkg::UPD_IR:   n = m ? bscan_pkg::SEL_DR   : bscan_pkg::RTI;
            default:             n = bscan_pkg::TLR;
        endcase
        return n;
    endfunction : tap_next

    logic [5:0]            sa_r;
    logic [5:0]            sb_r;
    logic [NPINS-1:0]      pa_r;
    logic [NPINS-1:0]      pb_r;
    logic                  tck_d_r;
    bscan_pkg::tap_state_e state_r;
    logic [3:0]            ir_sh_r;
    logic [3:0]            ir_r;
    logic                  bypass_r;
    logic [31:0]           id_sh_r;
    logic [RL-1:0]         ring_r;
    logic [NPINS-1:0]      latch_r;
    logic                  test_rst_r;
    logic [31:0]           tout_r;
    logic                  dis_r;
    logic                  isc_r;
    logic                  trf_r;
    logic [2:0]            pend_cnt_r;
    logic                  pend_val_r;

    // Two-stage sync: test clock, mode, data, fuses, external reset
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            sa_r <= bscan_pkg::SYNC_RESET;
            sb_r <= bscan_pkg::SYNC_RESET;
            pa_r <= '0;
            pb_r <= '0;
            tck_d_r <= 1'b0;
        end
        else
        begin
            sa_r <= {TCK_I, TMS_I, TDI_I, TAP_ENABLE_FUSE_I, TOUT_SEL_FUSE_I, EXT_RESET_N_I};
            sb_r <= sa_r;
            pa_r <= PIN_I;
            pb_r <= pa_r;
            tck_d_r <= sb_r[5];
        end
    end

    // Edge detection lets the test clock outrun nothing but half the core rate
    wire tck_rise = sb_r[5] & ~tck_d_r;
    wire tck_fall = ~sb_r[5] & tck_d_r;
    wire tms      = sb_r[4];
    wire tdi      = sb_r[3];
    wire fuse     = sb_r[2];
    wire tsel     = sb_r[1];
    wire ext_rst  = ~sb_r[0];
    wire tap_en   = fuse & ~dis_r;

    wire sel_ext    = (ir_r == bscan_pkg::OP_EXTEST);
    wire sel_sample = (ir_r == bscan_pkg::OP_SAMPLE);
    wire sel_id     = (ir_r == bscan_pkg::OP_IDCODE);
    wire sel_rst    = (ir_r == bscan_pkg::OP_PART_RESET);
    wire sel_ring   = sel_ext | sel_sample;
    // Unknown codes fall back to bypass
    wire sel_bypass = ~(sel_ring | sel_id | sel_rst);
    wire [31:0] id_word = {bscan_pkg::ID_REV, bscan_pkg::ID_PART, bscan_pkg::ID_MAKER, 1'b1};
    wire in_reset   = ext_rst | test_rst_r | (tout_r != 32'h0);
    wire [NPINS-1:0] pin_drv = sel_ext ? latch_r : SYS_OUT_I;
    wire cap_dr     = tck_rise & (state_r == bscan_pkg::CAP_DR);
    wire sh_dr      = tck_rise & (state_r == bscan_pkg::SHIFT_DR);
    wire tdo_bit    = (state_r == bscan_pkg::SHIFT_IR) ? ir_sh_r[0] :
                      sel_ring ? ring_r[0] : sel_id ? id_sh_r[0] :
                      sel_rst ? test_rst_r : bypass_r;
    wire shifting   = (state_r == bscan_pkg::SHIFT_IR) | (state_r == bscan_pkg::SHIFT_DR);
    wire wr_hit     = WR_I & (ADDR_I == bscan_pkg::CSR_ADDR);
    wire rd_hit     = RD_I & (ADDR_I == bscan_pkg::CSR_ADDR);
    wire [7:0] csr_val = {dis_r, isc_r, 1'b0, trf_r, 4'h0};

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I || !tap_en)
            state_r <= bscan_pkg::TLR;
        else if (tck_rise)
            state_r <= tap_next(state_r, tms);
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I || state_r == bscan_pkg::TLR)
            ir_r <= bscan_pkg::OP_IDCODE;
        else if (tck_rise && state_r == bscan_pkg::UPD_IR)
            ir_r <= ir_sh_r;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
            ir_sh_r <= bscan_pkg::IR_CAPTURE;
        else if (tck_rise && state_r == bscan_pkg::CAP_IR)
            ir_sh_r <= bscan_pkg::IR_CAPTURE;
        else if (tck_rise && state_r == bscan_pkg::SHIFT_IR)
            ir_sh_r <= {tdi, ir_sh_r[3:1]};
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            bypass_r <= 1'b0;
            id_sh_r  <= '0;
            ring_r   <= '0;
        end
        else if (cap_dr)
        begin
            bypass_r <= 1'b0;
            id_sh_r  <= id_word;
            if (sel_ring)
                ring_r <= {pin_drv, pb_r};
        end
        else if (sh_dr)
        begin
            if (sel_bypass)
                bypass_r <= tdi;
            if (sel_id)
                id_sh_r <= {tdi, id_sh_r[31:1]};
            if (sel_ring)
                ring_r <= {tdi, ring_r[RL-1:1]};
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
            latch_r <= '0;
        else if (tck_rise && state_r == bscan_pkg::UPD_DR && sel_ring)
            latch_r <= ring_r[RL-1:NPINS];
    end

    // No update stage: reset follows the shift cell directly
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I || !tap_en)
            test_rst_r <= 1'b0;
        else if (sh_dr && sel_rst)
            test_rst_r <= tdi;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
            tout_r <= '0;
        else if (ext_rst || test_rst_r)
            tout_r <= tsel ? 32'(TOUT_LONG) : 32'(TOUT_SHORT);
        else if (tout_r != 32'h0)
            tout_r <= tout_r - 32'h1;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            PART_RESET_O <= 1'b1;
            PIN_O        <= '0;
            PIN_OE_O     <= '0;
        end
        else
        begin
            PART_RESET_O <= in_reset;
            PIN_O        <= pin_drv;
            PIN_OE_O     <= in_reset ? '0 : (sel_ext ? '1 : SYS_OE_I);
        end
    end

    // Data out changes on the falling test-clock edge
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I || !tap_en)
        begin
            TDO_O    <= 1'b0;
            TDO_OE_O <= 1'b0;
        end
        else if (tck_fall)
        begin
            TDO_O    <= tdo_bit;
            TDO_OE_O <= shifting;
        end
    end

    // Timed change guards against a stray store killing the port
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            dis_r      <= bscan_pkg::CSR_RESET[bscan_pkg::DIS_BIT];
            isc_r      <= bscan_pkg::CSR_RESET[bscan_pkg::ISC_BIT];
            trf_r      <= bscan_pkg::CSR_RESET[bscan_pkg::TRF_BIT];
            pend_cnt_r <= 3'h0;
            pend_val_r <= 1'b0;
            RDATA_O    <= 8'h00;
        end
        else
        begin
            RDATA_O <= rd_hit ? csr_val : 8'h00;
            if (wr_hit)
                isc_r <= WDATA_I[bscan_pkg::ISC_BIT];
            if (test_rst_r)
                trf_r <= 1'b1;
            else if (wr_hit && !WDATA_I[bscan_pkg::TRF_BIT])
                trf_r <= 1'b0;
            if (wr_hit && pend_cnt_r != 3'h0 && WDATA_I[bscan_pkg::DIS_BIT] == pend_val_r)
            begin
                dis_r      <= pend_val_r;
                pend_cnt_r <= 3'h0;
            end
            else if (wr_hit)
            begin
                pend_cnt_r <= bscan_pkg::TIMED_WIN;
                pend_val_r <= WDATA_I[bscan_pkg::DIS_BIT];
            end
            else if (pend_cnt_r != 3'h0)
                pend_cnt_r <= pend_cnt_r - 3'h1;
        end
    end

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);

    AST_IR_DEFAULT: assert property (state_r == bscan_pkg::TLR |=> ir_r == bscan_pkg::OP_IDCODE)
        else $error("instruction not identification after tap reset");
    AST_EXTEST_DRIVE: assert property (sel_ext && !in_reset |=> PIN_O == $past(latch_r) && PIN_OE_O == '1)
        else $error("external test not driving latches");
    AST_SAMPLE_QUIET: assert property (sel_sample && !in_reset |=> PIN_O == $past(SYS_OUT_I) && PIN_OE_O == $past(SYS_OE_I))
        else $error("sample/preload disturbed pins");
    AST_RING_CAP: assert property (cap_dr && sel_ring |=> ring_r[NPINS-1:0] == $past(pb_r))
        else $error("ring did not capture pins");
    AST_BYPASS_CAP: assert property (cap_dr && sel_bypass |=> !bypass_r)
        else $error("bypass not zero after capture");
    AST_ID_CAP: assert property (cap_dr && sel_id |=> id_sh_r[0] && id_sh_r[31:28] == bscan_pkg::ID_REV)
        else $error("identification word wrong");
    AST_PORT_OFF: assert property (!tap_en |=> state_r == bscan_pkg::TLR ##1 !TDO_OE_O)
        else $error("port active while disabled");
    AST_RST_NOW: assert property (sh_dr && sel_rst && tdi |=> test_rst_r ##1 PART_RESET_O)
        else $error("test reset not immediate");
    AST_TOUT_HOLD: assert property ($fell(test_rst_r) && !ext_rst |-> PART_RESET_O [*3])
        else $error("reset released without time-out");
    AST_HIZ: assert property (in_reset |=> PIN_OE_O == '0)
        else $error("pins driven during reset");
    AST_ONE_WRITE: assert property (wr_hit && pend_cnt_r == 3'h0 |=> dis_r == $past(dis_r))
        else $error("single write changed disable bit");
    AST_TRF: assert property (test_rst_r |=> trf_r)
        else $error("test reset flag not set");

    COV_EXTEST: cover property (sel_ext && sh_dr);
    COV_TEST_RST: cover property ($fell(test_rst_r));
    COV_DISABLE: cover property ($rose(dis_r));
    COV_BYPASS: cover property (sel_bypass && sh_dr);
endmodule : bscan_tap
